// ==== pct_target_port.sv ====
`timescale 1ns/100ps
module pct_target_port #(
    parameter int          BAR_BITS  = 12,           // memory window size as a power of two
    parameter logic [15:0] VENDOR_ID = 16'h1234,     // arbitrary value
    parameter logic [15:0] DEVICE_ID = 16'h5678,     // arbitrary value
    parameter logic [7:0]  REV_ID    = 8'h01,        // arbitrary value
    parameter logic [23:0] CLASS_CODE = 24'h070002   // serial controller class
) (
    input  wire logic        clk_sys,          // bus clock
    input  wire logic        arst_n,           // bus reset
    input  wire logic [31:0] ad_i,             // address/data in
    output logic      [31:0] ad_o,             // address/data out
    output logic             ad_oe_n,          // address/data drive, low drives
    input  wire logic [3:0]  cbe_n_i,          // command/byte enables
    input  wire logic        par_i,            // parity in
    output logic             par_o,            // parity out
    output logic             par_oe_n,         // parity drive, low drives
    input  wire logic        frame_n_i,        // frame
    input  wire logic        irdy_n_i,         // initiator ready
    input  wire logic        idsel_i,          // configuration select
    output logic             trdy_n_o,         // target ready
    output logic             trdy_oe_n,        // target ready drive
    output logic             stop_n_o,         // stop request
    output logic             stop_oe_n,        // stop drive
    output logic             devsel_n_o,       // device select
    output logic             devsel_oe_n,      // device select drive
    output logic             perr_n_o,         // data parity error
    output logic             perr_oe_n,        // data parity error drive
    output logic             serr_n_o,         // system error level, always low
    output logic             serr_oe_n,        // system error pull, low pulls
    output logic             inta_n_o,         // interrupt level, always low
    output logic             inta_oe_n,        // interrupt pull, low pulls
    output logic             pme_n_o,          // power event level, always low
    output logic             pme_oe_n,         // power event pull, low pulls
    input  wire logic [7:0]  chan_irq_i,       // per-channel interrupt pending
    input  wire logic [7:0]  chan_rx_new_i,    // per-channel new character pulse
    input  wire logic [7:0]  chan_modem_chg_i  // per-channel modem change pulse
);
    localparam logic [31:0] BAR_MASK = 32'hFFFF_FFFF << BAR_BITS;

    pct_pkg::pct_state_t st_ff, nxt_st;
    logic [31:0] addr_ff, nxt_addr, bar_ff, nxt_bar, ad_o_ff, nxt_ad_o;
    logic [15:0] cmd_ff, nxt_cmd;
    logic [3:0]  bus_cmd_ff, nxt_bus_cmd;
    logic [7:0]  int_en_ff, nxt_int_en, int_ln_ff, nxt_int_ln;
    logic [1:0]  pstate_ff, nxt_pstate;
    logic        idsel_ff, nxt_idsel, exp_par_ff, nxt_exp_par;
    logic        adr_chk_ff, nxt_adr_chk, dat_chk_ff, nxt_dat_chk;
    logic        dpe_ff, nxt_dpe, sse_ff, nxt_sse, pme_en_ff, nxt_pme_en, pme_st_ff, nxt_pme_st;
    logic        ad_oe_n_ff, nxt_ad_oe_n, par_o_ff, nxt_par_o, par_oe_n_ff, nxt_par_oe_n;
    logic        trdy_ff, nxt_trdy, stop_ff, nxt_stop, devsel_ff, nxt_devsel, tso_oe_n_ff, nxt_tso_oe_n;
    logic        perr_ff, nxt_perr, perr_oe_n_ff, nxt_perr_oe_n;
    logic        serr_oe_n_ff, nxt_serr_oe_n, inta_oe_n_ff, nxt_inta_oe_n, pme_oe_n_ff, nxt_pme_oe_n;
    logic        od_low_ff;
    logic        par_in, par_out, is_cfg_cmd, is_mem_cmd, cfg_hit, mem_hit, int_pend;
    logic [31:0] rd_data, mem_ofs;
    logic [15:0] stat_word, pmcsr_word;

    pct_even_par u_par_in (
        .ad    (ad_i),
        .cbe_n (cbe_n_i),
        .par   (par_in)
    );
    pct_even_par u_par_out (
        .ad    (ad_o_ff),
        .cbe_n (cbe_n_i),
        .par   (par_out)
    );

    always_comb begin
        is_cfg_cmd = (bus_cmd_ff == pct_pkg::CMD_CFG_RD) || (bus_cmd_ff == pct_pkg::CMD_CFG_WR);
        is_mem_cmd = (bus_cmd_ff == pct_pkg::CMD_MEM_RD) || (bus_cmd_ff == pct_pkg::CMD_MEM_WR)
                   || (bus_cmd_ff == pct_pkg::CMD_MEM_RDM) || (bus_cmd_ff == pct_pkg::CMD_MEM_RDL)
                   || (bus_cmd_ff == pct_pkg::CMD_MEM_WRI);
        cfg_hit = is_cfg_cmd && idsel_ff && (addr_ff[1:0] == 2'h0) && (addr_ff[10:8] == 3'h0);
        mem_hit = is_mem_cmd && cmd_ff[pct_pkg::CMD_MEM_EN] && (addr_ff[1:0] == 2'h0)
                && (((addr_ff ^ bar_ff) & BAR_MASK) == 32'h0000_0000);
        mem_ofs = addr_ff & ~BAR_MASK;
        int_pend = |(chan_irq_i & int_en_ff);
        stat_word = 16'h0000;
        stat_word[pct_pkg::STAT_DPE] = dpe_ff;
        stat_word[pct_pkg::STAT_SSE] = sse_ff;
        stat_word[pct_pkg::STAT_CAP] = 1'b1;
        stat_word[pct_pkg::STAT_INT] = int_pend;
        pmcsr_word = 16'h0000;
        pmcsr_word[1:0] = pstate_ff;
        pmcsr_word[pct_pkg::PMCSR_PME_EN] = pme_en_ff;
        pmcsr_word[pct_pkg::PMCSR_PME_ST] = pme_st_ff;
        rd_data = 32'h0000_0000;
        if (is_cfg_cmd) begin
            if (addr_ff[7:2] == pct_pkg::CFG_ID) begin
                rd_data = {DEVICE_ID, VENDOR_ID};
            end else if (addr_ff[7:2] == pct_pkg::CFG_CMDSTAT) begin
                rd_data = {stat_word, cmd_ff};
            end else if (addr_ff[7:2] == pct_pkg::CFG_CLASS) begin
                rd_data = {CLASS_CODE, REV_ID};
            end else if (addr_ff[7:2] == pct_pkg::CFG_BAR0) begin
                rd_data = bar_ff;
            end else if (addr_ff[7:2] == pct_pkg::CFG_CAPPTR) begin
                rd_data = {24'h00_0000, pct_pkg::PM_CAP_OFS};
            end else if (addr_ff[7:2] == pct_pkg::CFG_INTR) begin
                rd_data = {16'h0000, pct_pkg::INT_PIN, int_ln_ff};
            end else if (addr_ff[7:2] == pct_pkg::CFG_PMCAP) begin
                rd_data = {pct_pkg::PM_PMC, 8'h00, pct_pkg::PM_CAP_ID};
            end else if (addr_ff[7:2] == pct_pkg::CFG_PMCSR) begin
                rd_data = {16'h0000, pmcsr_word};
            end
        end else if (mem_ofs == pct_pkg::MEM_OFS_INT_SRC) begin
            rd_data = {24'h00_0000, chan_irq_i};
        end else if (mem_ofs == pct_pkg::MEM_OFS_INT_EN) begin
            rd_data = {24'h00_0000, int_en_ff};
        end
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_addr = addr_ff;
        nxt_bus_cmd = bus_cmd_ff;
        nxt_idsel = idsel_ff;
        nxt_bar = bar_ff;
        nxt_cmd = cmd_ff;
        nxt_int_en = int_en_ff;
        nxt_int_ln = int_ln_ff;
        nxt_pstate = pstate_ff;
        nxt_pme_en = pme_en_ff;
        nxt_pme_st = pme_st_ff;
        nxt_dpe = dpe_ff;
        nxt_sse = sse_ff;
        nxt_exp_par = exp_par_ff;
        nxt_adr_chk = 1'b0;
        nxt_dat_chk = 1'b0;
        nxt_ad_o = ad_o_ff;
        nxt_ad_oe_n = ad_oe_n_ff;
        nxt_par_o = par_out;
        nxt_par_oe_n = ad_oe_n_ff;
        nxt_trdy = trdy_ff;
        nxt_stop = stop_ff;
        nxt_devsel = devsel_ff;
        nxt_tso_oe_n = tso_oe_n_ff;
        nxt_perr = perr_ff;
        nxt_perr_oe_n = perr_oe_n_ff;
        nxt_serr_oe_n = 1'b1;
        case (st_ff)
            pct_pkg::ST_IDLE: begin
                if (!frame_n_i) begin
                    nxt_addr = ad_i;
                    nxt_bus_cmd = cbe_n_i;
                    nxt_idsel = idsel_i;
                    nxt_exp_par = par_in;
                    nxt_adr_chk = 1'b1;
                    nxt_st = pct_pkg::ST_DECODE;
                end
            end
            pct_pkg::ST_DECODE: begin
                if (cfg_hit || mem_hit) begin
                    nxt_devsel = 1'b0;
                    nxt_trdy = 1'b0;
                    nxt_stop = 1'b0;
                    nxt_tso_oe_n = 1'b0;
                    if (!bus_cmd_ff[0]) begin
                        nxt_ad_o = rd_data;
                        nxt_ad_oe_n = 1'b0;
                    end
                    nxt_st = pct_pkg::ST_DATA;
                end else begin
                    nxt_st = pct_pkg::ST_BUSY;
                end
            end
            pct_pkg::ST_DATA: begin
                if (!irdy_n_i) begin
                    nxt_trdy = 1'b1;
                    nxt_ad_oe_n = 1'b1;
                    if (bus_cmd_ff[0]) begin
                        nxt_exp_par = par_in;
                        nxt_dat_chk = 1'b1;
                        if (is_cfg_cmd && (addr_ff[7:2] == pct_pkg::CFG_CMDSTAT)) begin
                            for (int b = 0; b < 2; b++) begin
                                if (!cbe_n_i[b]) begin
                                    nxt_cmd[b*8 +: 8] = ad_i[b*8 +: 8] & pct_pkg::CMD_WMASK[b*8 +: 8];
                                end
                            end
                            if (!cbe_n_i[3] && ad_i[16 + pct_pkg::STAT_DPE]) begin
                                nxt_dpe = 1'b0;
                            end
                            if (!cbe_n_i[3] && ad_i[16 + pct_pkg::STAT_SSE]) begin
                                nxt_sse = 1'b0;
                            end
                        end else if (is_cfg_cmd && (addr_ff[7:2] == pct_pkg::CFG_BAR0)) begin
                            for (int b = 0; b < 4; b++) begin
                                if (!cbe_n_i[b]) begin
                                    nxt_bar[b*8 +: 8] = ad_i[b*8 +: 8] & BAR_MASK[b*8 +: 8];
                                end
                            end
                        end else if (is_cfg_cmd && (addr_ff[7:2] == pct_pkg::CFG_INTR)) begin
                            if (!cbe_n_i[0]) begin
                                nxt_int_ln = ad_i[7:0];
                            end
                        end else if (is_cfg_cmd && (addr_ff[7:2] == pct_pkg::CFG_PMCSR)) begin
                            if (!cbe_n_i[0]) begin
                                nxt_pstate = ad_i[1:0];
                            end
                            if (!cbe_n_i[1]) begin
                                nxt_pme_en = ad_i[pct_pkg::PMCSR_PME_EN];
                                if (ad_i[pct_pkg::PMCSR_PME_ST]) begin
                                    nxt_pme_st = 1'b0;
                                end
                            end
                        end else if (!is_cfg_cmd && (mem_ofs == pct_pkg::MEM_OFS_INT_EN)) begin
                            if (!cbe_n_i[0]) begin
                                nxt_int_en = ad_i[7:0];
                            end
                        end
                    end
                    if (frame_n_i) begin
                        nxt_devsel = 1'b1;
                        nxt_stop = 1'b1;
                        nxt_st = pct_pkg::ST_TURN;
                    end else begin
                        nxt_st = pct_pkg::ST_STOP;
                    end
                end
            end
            pct_pkg::ST_STOP: begin
                if (frame_n_i) begin
                    nxt_devsel = 1'b1;
                    nxt_stop = 1'b1;
                    nxt_st = pct_pkg::ST_TURN;
                end
            end
            pct_pkg::ST_TURN: begin
                nxt_tso_oe_n = 1'b1;
                nxt_st = pct_pkg::ST_IDLE;
            end
            default: begin
                if (frame_n_i && irdy_n_i) begin
                    nxt_st = pct_pkg::ST_IDLE;
                end
            end
        endcase
        // data parity error output: low one cycle, high one cycle, then released
        if (!perr_oe_n_ff && !perr_ff) begin
            nxt_perr = 1'b1;
        end else if (!perr_oe_n_ff) begin
            nxt_perr_oe_n = 1'b1;
        end
        // error flags are set after any software clear so a coincident event wins
        if (dat_chk_ff && (par_i != exp_par_ff)) begin
            nxt_dpe = 1'b1;
            if (cmd_ff[pct_pkg::CMD_PERR_RSP]) begin
                nxt_perr = 1'b0;
                nxt_perr_oe_n = 1'b0;
            end
        end
        if (adr_chk_ff && (par_i != exp_par_ff)) begin
            nxt_dpe = 1'b1;
            if (cmd_ff[pct_pkg::CMD_PERR_RSP] && cmd_ff[pct_pkg::CMD_SERR_EN]) begin
                nxt_sse = 1'b1;
                nxt_serr_oe_n = 1'b0;
            end
        end
        if ((pstate_ff == pct_pkg::PS_D3HOT) && pme_en_ff && (|(chan_rx_new_i | chan_modem_chg_i))) begin
            nxt_pme_st = 1'b1;
        end
        nxt_inta_oe_n = !(int_pend && !cmd_ff[pct_pkg::CMD_INT_DIS]);
        nxt_pme_oe_n = !(nxt_pme_st && nxt_pme_en);
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= pct_pkg::ST_IDLE;
            addr_ff <= 32'h0000_0000;
            bus_cmd_ff <= 4'h0;
            idsel_ff <= 1'b0;
            bar_ff <= pct_pkg::BAR_RST;
            cmd_ff <= pct_pkg::CMD_RST;
            int_en_ff <= pct_pkg::INT_EN_RST;
            int_ln_ff <= pct_pkg::INT_LN_RST;
            pstate_ff <= pct_pkg::PS_D0;
            pme_en_ff <= 1'b0;
            pme_st_ff <= 1'b0;
            dpe_ff <= 1'b0;
            sse_ff <= 1'b0;
            exp_par_ff <= 1'b0;
            adr_chk_ff <= 1'b0;
            dat_chk_ff <= 1'b0;
            ad_o_ff <= 32'h0000_0000;
            ad_oe_n_ff <= 1'b1;
            par_o_ff <= 1'b0;
            par_oe_n_ff <= 1'b1;
            trdy_ff <= 1'b1;
            stop_ff <= 1'b1;
            devsel_ff <= 1'b1;
            tso_oe_n_ff <= 1'b1;
            perr_ff <= 1'b1;
            perr_oe_n_ff <= 1'b1;
            serr_oe_n_ff <= 1'b1;
            inta_oe_n_ff <= 1'b1;
            pme_oe_n_ff <= 1'b1;
            od_low_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            addr_ff <= nxt_addr;
            bus_cmd_ff <= nxt_bus_cmd;
            idsel_ff <= nxt_idsel;
            bar_ff <= nxt_bar;
            cmd_ff <= nxt_cmd;
            int_en_ff <= nxt_int_en;
            int_ln_ff <= nxt_int_ln;
            pstate_ff <= nxt_pstate;
            pme_en_ff <= nxt_pme_en;
            pme_st_ff <= nxt_pme_st;
            dpe_ff <= nxt_dpe;
            sse_ff <= nxt_sse;
            exp_par_ff <= nxt_exp_par;
            adr_chk_ff <= nxt_adr_chk;
            dat_chk_ff <= nxt_dat_chk;
            ad_o_ff <= nxt_ad_o;
            ad_oe_n_ff <= nxt_ad_oe_n;
            par_o_ff <= nxt_par_o;
            par_oe_n_ff <= nxt_par_oe_n;
            trdy_ff <= nxt_trdy;
            stop_ff <= nxt_stop;
            devsel_ff <= nxt_devsel;
            tso_oe_n_ff <= nxt_tso_oe_n;
            perr_ff <= nxt_perr;
            perr_oe_n_ff <= nxt_perr_oe_n;
            serr_oe_n_ff <= nxt_serr_oe_n;
            inta_oe_n_ff <= nxt_inta_oe_n;
            pme_oe_n_ff <= nxt_pme_oe_n;
            od_low_ff <= 1'b0;
        end
    end

    assign ad_o = ad_o_ff;
    assign ad_oe_n = ad_oe_n_ff;
    assign par_o = par_o_ff;
    assign par_oe_n = par_oe_n_ff;
    assign trdy_n_o = trdy_ff;
    assign stop_n_o = stop_ff;
    assign devsel_n_o = devsel_ff;
    assign trdy_oe_n = tso_oe_n_ff;
    assign stop_oe_n = tso_oe_n_ff;
    assign devsel_oe_n = tso_oe_n_ff;
    assign perr_n_o = perr_ff;
    assign perr_oe_n = perr_oe_n_ff;
    assign serr_n_o = od_low_ff;
    assign serr_oe_n = serr_oe_n_ff;
    assign inta_n_o = od_low_ff;
    assign inta_oe_n = inta_oe_n_ff;
    assign pme_n_o = od_low_ff;
    assign pme_oe_n = pme_oe_n_ff;
endmodule

// ==== pct_pkg.sv ====
package pct_pkg;
    // bus commands as carried on the command lines
    localparam logic [3:0] CMD_MEM_RD  = 4'h6;
    localparam logic [3:0] CMD_MEM_WR  = 4'h7;
    localparam logic [3:0] CMD_CFG_RD  = 4'hA;
    localparam logic [3:0] CMD_CFG_WR  = 4'hB;
    localparam logic [3:0] CMD_MEM_RDM = 4'hC;
    localparam logic [3:0] CMD_MEM_RDL = 4'hE;
    localparam logic [3:0] CMD_MEM_WRI = 4'hF;
    // configuration dword indices and fixed register values
    localparam logic [5:0] CFG_ID      = 6'h00;
    localparam logic [5:0] CFG_CMDSTAT = 6'h01;
    localparam logic [5:0] CFG_CLASS   = 6'h02;
    localparam logic [5:0] CFG_BAR0    = 6'h04;
    localparam logic [5:0] CFG_CAPPTR  = 6'h0D;
    localparam logic [5:0] CFG_INTR    = 6'h0F;
    localparam logic [5:0] CFG_PMCAP   = 6'h10;
    localparam logic [5:0] CFG_PMCSR   = 6'h11;
    localparam logic [7:0] PM_CAP_OFS  = 8'h40;
    localparam logic [7:0] PM_CAP_ID   = 8'h01;
    localparam logic [15:0] PM_PMC     = 16'h4002;
    localparam logic [7:0] INT_PIN     = 8'h01;
    // command register bits
    localparam int CMD_MEM_EN   = 1;
    localparam int CMD_PERR_RSP = 6;
    localparam int CMD_SERR_EN  = 8;
    localparam int CMD_INT_DIS  = 10;
    localparam logic [15:0] CMD_WMASK = 16'h0542;
    // status register bits
    localparam int STAT_INT = 3;
    localparam int STAT_CAP = 4;
    localparam int STAT_SSE = 14;
    localparam int STAT_DPE = 15;
    // power management control/status bits
    localparam int PMCSR_PME_EN = 8;
    localparam int PMCSR_PME_ST = 15;
    localparam logic [1:0] PS_D0    = 2'h0;
    localparam logic [1:0] PS_D3HOT = 2'h3;
    // memory window byte offsets
    localparam logic [31:0] MEM_OFS_INT_SRC = 32'h0000_0000;
    localparam logic [31:0] MEM_OFS_INT_EN  = 32'h0000_0004;
    // reset values
    localparam logic [15:0] CMD_RST    = 16'h0000;
    localparam logic [31:0] BAR_RST    = 32'h0000_0000;
    localparam logic [7:0]  INT_EN_RST = 8'h00;
    localparam logic [7:0]  INT_LN_RST = 8'h00;
    typedef enum logic [2:0] {ST_IDLE, ST_DECODE, ST_DATA, ST_STOP, ST_TURN, ST_BUSY} pct_state_t;
endpackage

// ==== pct_even_par.sv ====
`timescale 1ns/100ps
module pct_even_par (
    input  wire logic [31:0] ad,     // address/data bits
    input  wire logic [3:0]  cbe_n,  // command/byte enable bits
    output logic             par     // bit making the 37-bit total even
);
    assign par = ^{ad, cbe_n};
endmodule

// ==== pct_host_model.sv ====
`timescale 1ns/100ps
module pct_host_model (
    input  wire logic        clk_sys,   // clock
    output logic      [31:0] ad_i,      // ad wire
    output logic      [3:0]  cbe_n_i,   // cmd/be
    output logic             par_i,     // par wire
    output logic             frame_n_i, // frame
    output logic             irdy_n_i,  // ready
    output logic             idsel_i,   // select
    input  wire logic [31:0] ad_o,      // read data
    input  wire logic        ad_oe_n,   // ad drive
    input  wire logic        par_o,     // parity
    input  wire logic        par_oe_n,  // par drive
    input  wire logic        trdy_n_o   // target ready
);
    logic [31:0] m_ad;
    logic        m_par;
    // a released line shows a changing pattern, never the last value
    assign ad_i = ad_oe_n ? m_ad : ad_o;
    assign par_i = par_oe_n ? m_par : par_o;
    initial begin
        m_ad = 32'h0;
        m_par = 1'b0;
        cbe_n_i = 4'hF;
        frame_n_i = 1'b1;
        irdy_n_i = 1'b1;
        idsel_i = 1'b0;
    end
    // bad[0] spoils address parity, bad[1] write data parity
    task automatic xfer(input logic [3:0] cmd, input logic [31:0] adr, input logic sel, input logic [3:0] be,
                        input logic [31:0] wd, input logic [1:0] bad, output logic [31:0] rd, output logic hit);
        hit = 1'b0;
        rd = 32'h0;
        @(negedge clk_sys);
        frame_n_i = 1'b0;
        m_ad = adr;
        cbe_n_i = cmd;
        idsel_i = sel;
        @(negedge clk_sys);
        m_par = ^{adr, cmd} ^ bad[0];
        frame_n_i = 1'b1;
        irdy_n_i = 1'b0;
        idsel_i = 1'b0;
        cbe_n_i = be;
        m_ad = cmd[0] ? wd : ~adr;
        // sample mid-cycle while the answer stands; the next rising edge completes the phase
        for (int n = 0; n < 6 && !hit; n++) begin
            @(negedge clk_sys);
            hit = !trdy_n_o;
            rd = ad_i;
        end
        @(negedge clk_sys);
        irdy_n_i = 1'b1;
        m_par = ^{m_ad, be} ^ bad[1];
        m_ad = ~m_ad;
        @(negedge clk_sys);
        m_par = ~m_par;
        repeat (3) @(negedge clk_sys);
    endtask
endmodule

// ==== pct_target_port_monitor.sv ====
`timescale 1ns/100ps
module pct_target_port_monitor (
    input wire logic        clk_sys,    // clock
    input wire logic        arst_n,     // reset
    input wire logic [31:0] ad_i,       // ad in
    input wire logic [31:0] ad_o,       // ad out
    input wire logic        ad_oe_n,    // ad drive
    input wire logic [3:0]  cbe_n_i,    // cmd/be
    input wire logic        par_i,      // par in
    input wire logic        par_o,      // par out
    input wire logic        par_oe_n,   // par drive
    input wire logic        irdy_n_i,   // ready
    input wire logic        frame_n_i,  // frame
    input wire logic        trdy_n_o,   // target ready
    input wire logic        stop_n_o,   // stop
    input wire logic        devsel_n_o, // select
    input wire logic        perr_n_o,   // perr
    input wire logic        perr_oe_n,  // perr drive
    input wire logic        serr_n_o,   // serr
    input wire logic        serr_oe_n,  // serr pull
    input wire logic        inta_n_o,   // irq
    input wire logic        inta_oe_n,  // irq pull
    input wire logic        pme_n_o,    // event
    input wire logic        pme_oe_n,   // event pull
    input wire logic [7:0]  chan_irq_i  // irq pending
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    par_even_a: assert property (!par_oe_n |-> par_o == ^{$past(ad_o), $past(cbe_n_i)})
        else $error("read parity odd");
    claim_lat_a: assert property ($fell(devsel_n_o) |-> $past(frame_n_i, 2) == 1'b0)
        else $error("claim latency");
    trdy_done_a: assert property (!trdy_n_o && !irdy_n_i |=> trdy_n_o)
        else $error("trdy held");
    stop_pair_a: assert property ($fell(trdy_n_o) |-> !stop_n_o && !devsel_n_o)
        else $error("stop missing");
    ad_phase_a: assert property ($fell(ad_oe_n) |-> !trdy_n_o ##1 ad_oe_n)
        else $error("ad drive");
    perr_pulse_a: assert property ($fell(perr_n_o) |-> !perr_oe_n ##1 perr_n_o && !perr_oe_n ##1 perr_oe_n)
        else $error("perr shape");
    serr_cause_a: assert property (!serr_oe_n |-> $past(par_i) != ^{$past(ad_i, 2), $past(cbe_n_i, 2)} ##1 serr_oe_n)
        else $error("serr cause");
    od_low_a: assert property (!serr_n_o && !inta_n_o && !pme_n_o)
        else $error("open drain high");
    irq_idle_a: assert property (chan_irq_i == 8'h00 |=> inta_oe_n)
        else $error("irq idle");
    read_c: cover property ($fell(ad_oe_n));
    serr_c: cover property (!serr_oe_n);
    pme_c: cover property ($fell(pme_oe_n));
endmodule
bind pct_target_port pct_target_port_monitor mon (.*);

// ==== tb.sv ====
`timescale 1ns/100ps
`define check_eq(what, exp, got) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("FAIL %s exp %h got %h", what, exp, got); \
        end \
    end
module tb;
    localparam logic [3:0] CR = pct_pkg::CMD_CFG_RD;
    localparam logic [3:0] CW = pct_pkg::CMD_CFG_WR;
    localparam logic [3:0] MR = pct_pkg::CMD_MEM_RD;
    localparam logic [3:0] MW = pct_pkg::CMD_MEM_WR;
    logic        clk_sys = 1'b0;
    logic        arst_n = 1'b0;
    logic [31:0] ad_i, ad_o, rd;
    logic [7:0]  chan_irq_i = 8'h00, chan_rx_new_i = 8'h00, chan_modem_chg_i = 8'h00;
    logic [3:0]  cbe_n_i;
    logic        par_i, par_o, par_oe_n, ad_oe_n, frame_n_i, irdy_n_i, idsel_i, hit, serr_seen, perr_seen;
    logic        trdy_n_o, trdy_oe_n, stop_n_o, stop_oe_n, devsel_n_o, devsel_oe_n, perr_n_o, perr_oe_n;
    logic        serr_n_o, serr_oe_n, inta_n_o, inta_oe_n, pme_n_o, pme_oe_n;
    int          mismatches = 0, n_checks = 0, cycles = 0;
    // identity values are arbitrary
    pct_target_port #(.VENDOR_ID(16'h1A2B), .DEVICE_ID(16'h3C4D)) uut (.*);
    pct_host_model host (.*);
    always #50 clk_sys = ~clk_sys;
    always @(negedge clk_sys) begin
        cycles++;
        if (!serr_oe_n)
            serr_seen = 1'b1;
        if (!perr_n_o && !perr_oe_n)
            perr_seen = 1'b1;
        if (cycles == 3000) begin
            mismatches++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (mismatches == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic acc(input logic [3:0] c, input logic [31:0] a, input logic s, input logic [3:0] be,
                       input logic [31:0] wd);
        host.xfer(c, a, s, be, wd, 2'b00, rd, hit);
    endtask
    task automatic t_reset();
        `check_eq("oe idle", 8'hFF, {ad_oe_n, trdy_oe_n, stop_oe_n, devsel_oe_n, perr_oe_n, serr_oe_n, inta_oe_n, pme_oe_n})
        acc(CR, 32'h0000_0004, 1'b1, 4'h0, 32'h0);
        `check_eq("cmd status", 32'h0010_0000, rd)
        acc(CR, 32'h0000_0010, 1'b1, 4'h0, 32'h0);
        `check_eq("bar reset", 32'h0000_0000, rd)
    endtask
    task automatic t_cfg();
        acc(CR, 32'h0000_0000, 1'b0, 4'h0, 32'h0);
        `check_eq("no idsel", 1'b0, hit)
        acc(CR, 32'h0000_0000, 1'b1, 4'h0, 32'h0);
        `check_eq("ident", 32'h3C4D_1A2B, rd)
        acc(CW, 32'h0000_0004, 1'b1, 4'hC, 32'hFFFF_FFFF);
        acc(CR, 32'h0000_0004, 1'b1, 4'h0, 32'h0);
        `check_eq("cmd mask", {16'h0010, pct_pkg::CMD_WMASK}, rd)
        acc(CW, 32'h0000_0010, 1'b1, 4'h0, 32'hFFFF_FFFF);
        acc(CR, 32'h0000_0010, 1'b1, 4'h0, 32'h0);
        `check_eq("bar size", 32'hFFFF_F000, rd)
        acc(CR, 32'h0000_0040, 1'b1, 4'h0, 32'h0);
        `check_eq("pm cap", {pct_pkg::PM_PMC, 8'h00, pct_pkg::PM_CAP_ID}, rd)
        acc(CW, 32'h0000_003C, 1'b1, 4'h0, 32'h0000_0055);
        acc(CR, 32'h0000_003C, 1'b1, 4'h0, 32'h0);
        `check_eq("int line", {16'h0000, pct_pkg::INT_PIN, 8'h55}, rd)
        acc(CW, 32'h0000_0010, 1'b1, 4'h0, 32'h8000_0000);
        acc(CW, 32'h0000_0004, 1'b1, 4'hC, 32'h0000_0142);
    endtask
    task automatic t_mem();
        logic [3:0] rc[3] = '{MR, pct_pkg::CMD_MEM_RDM, pct_pkg::CMD_MEM_RDL};
        chan_irq_i = 8'hA5;
        foreach (rc[i]) begin
            acc(rc[i], 32'h8000_0000, 1'b0, 4'h0, 32'h0);
            `check_eq("irq source", 32'h0000_00A5, rd)
        end
        acc(MR, 32'h8000_1000, 1'b0, 4'h0, 32'h0);
        `check_eq("outside bar", 1'b0, hit)
        acc(4'h2, 32'h8000_0000, 1'b0, 4'h0, 32'h0);
        `check_eq("io ignored", 1'b0, hit)
        acc(pct_pkg::CMD_MEM_WRI, 32'h8000_0004, 1'b0, 4'hE, 32'hFFFF_FF01);
        acc(MR, 32'h8000_0004, 1'b0, 4'h0, 32'h0);
        `check_eq("irq enable", 32'h0000_0001, rd)
        `check_eq("irq pulled", 2'b00, {inta_oe_n, inta_n_o})
        chan_irq_i = 8'h04;
        repeat (3) @(negedge clk_sys);
        `check_eq("irq masked", 1'b1, inta_oe_n)
    endtask
    task automatic t_par();
        serr_seen = 1'b0;
        perr_seen = 1'b0;
        host.xfer(CR, 32'h0000_0000, 1'b1, 4'h0, 32'h0, 2'b01, rd, hit);
        `check_eq("addr par err", 2'b10, {serr_seen, perr_seen})
        host.xfer(MW, 32'h8000_0004, 1'b0, 4'hE, 32'h0, 2'b10, rd, hit);
        `check_eq("data par err", 1'b1, perr_seen)
        acc(CR, 32'h0000_0004, 1'b1, 4'h0, 32'h0);
        `check_eq("err status", 2'b11, rd[31:30])
        acc(CW, 32'h0000_0004, 1'b1, 4'h0, 32'hC000_0142);
        acc(CR, 32'h0000_0004, 1'b1, 4'h0, 32'h0);
        `check_eq("err cleared", 2'b00, rd[31:30])
    endtask
    task automatic t_pme();
        acc(CW, 32'h0000_0044, 1'b1, 4'h0, 32'h0000_0100);
        chan_rx_new_i = 8'h10;
        @(negedge clk_sys);
        chan_rx_new_i = 8'h00;
        repeat (2) @(negedge clk_sys);
        `check_eq("pme in d0", 1'b1, pme_oe_n)
        acc(CW, 32'h0000_0044, 1'b1, 4'h0, 32'h0000_0103);
        chan_modem_chg_i = 8'h80;
        @(negedge clk_sys);
        chan_modem_chg_i = 8'h00;
        repeat (2) @(negedge clk_sys);
        `check_eq("pme wake", 2'b00, {pme_oe_n, pme_n_o})
        acc(CR, 32'h0000_0044, 1'b1, 4'h0, 32'h0);
        `check_eq("pme status", 32'h0000_8103, rd)
        acc(CW, 32'h0000_0044, 1'b1, 4'h0, 32'h0000_8003);
        `check_eq("pme cleared", 1'b1, pme_oe_n)
    endtask
    initial begin
        repeat (16) @(negedge clk_sys);
        arst_n = 1'b1;
        t_reset();
        t_cfg();
        t_mem();
        t_par();
        t_pme();
        end_of_test();
    end
endmodule
